//--- bench/cpd_rc_pin.sv
`timescale 1ns/1ps
`default_nettype none
module cpd_rc_pin (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        drive_n,
  input  wire logic        drive_val,
  input  wire logic        rest,
  input  wire logic [31:0] decay,
  output logic             level
);
  logic [31:0] cnt;
  logic        armed;
  // capacitor follows the driver, drifts back to rest after decay cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level <= rest;
      armed <= 1'b0;
      cnt   <= '0;
    end
    else if (!drive_n)
    begin
      level <= drive_val;
      armed <= 1'b1;
      cnt   <= '0;
    end
    else if (armed)
    begin
      if (cnt >= decay)
      begin
        armed <= 1'b0;
        level <= rest;
      end
      else
      begin
        cnt <= cnt + 1;
      end
    end
    else
    begin
      level <= rest;
    end
  end
endmodule : cpd_rc_pin
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module testbench;
  import cpd_pkg::*;
  localparam int         TPC = 25;
  localparam logic [2:0] RC_REST = 3'b010;
  localparam logic [7:0] RC_TICKS [3] = '{8'h13, 8'h7f, 8'h00};
  localparam logic [15:0] CFG [4] = '{16'h03f0, 16'h04f0, 16'h0600, 16'h0702};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  port_a_out;
  logic [7:0]  port_a_oe_n;
  logic [7:0]  port_b_out;
  logic [7:0]  port_b_oe_n;
  logic        single_line_bus_mode;
  logic        sense;
  logic        rest;
  logic [31:0] decay;
  logic [31:0] rd;
  logic [31:0] ans;
  logic        err;
  int          fail_count;
  int          n_checks;
  int          hi;
  int          per;

  cpd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_in({7'h2a, sense}), .port_a_out(port_a_out),
    .port_a_oe_n(port_a_oe_n), .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
    .single_line_bus_mode(single_line_bus_mode));

  cpd_rc_pin rc (.pclk(pclk), .presetn(presetn), .drive_n(port_a_oe_n[0]),
    .drive_val(port_a_out[0]), .rest(rest), .decay(decay), .level(sense));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100)
      fail_count++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic put(input logic [15:0] m, input logic err_exp);
    apb(1'b1, ADDR_MSG, {16'h0000, m});
    `CHK(err, err_exp)
  endtask : put

  task automatic get_ans;
    int n;
    n  = 0;
    rd = '0;
    while (rd[16] !== 1'b1 && n < 5000)
    begin
      apb(1'b0, ADDR_ANSWER, 32'h0);
      n++;
    end
    if (rd[16] !== 1'b1)
      fail_count++;
    ans = rd;
  endtask : get_ans

  task automatic send(input logic [15:0] m, input logic [31:0] exp_ans);
    put(m, 1'b0);
    get_ans();
    `CHK(ans, exp_ans)
  endtask : send

  // one full pwm period, sampled mid-cycle
  task automatic meas;
    int n;
    n   = 0;
    hi  = 0;
    per = 0;
    while (port_b_out[1] !== 1'b0 && n < 70000)
    begin
      @(negedge pclk);
      n++;
    end
    while (port_b_out[1] !== 1'b1 && n < 70000)
    begin
      @(negedge pclk);
      n++;
    end
    while (port_b_out[1] === 1'b1 && n < 70000)
    begin
      @(negedge pclk);
      hi++;
      per++;
      n++;
    end
    while (port_b_out[1] === 1'b0 && n < 70000)
    begin
      @(negedge pclk);
      per++;
      n++;
    end
    if (n >= 70000)
      fail_count++;
  endtask : meas

  initial
  begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    rest    = 1'b0;
    decay   = 32'd1000;
    fail_count = 0;
    n_checks   = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h014, 32'h0);
    `CHK({err, rd, pready}, {1'b1, 32'h0, 1'b1})
    `CHK(port_b_out, 8'h00)
    send(16'h1f08, 32'h0001_3f08);
    `CHK(single_line_bus_mode, 1'b1)
    // sense pin high-z, pwm pin output, before use
    for (int i = 0; i < 4; i++)
      send(CFG[i], {16'h0001, CFG[i] | 16'h2000});
    `CHK({port_a_out, port_a_oe_n, port_b_oe_n}, 24'hf00ffd)
    for (int i = 0; i < 3; i++)
    begin
      rest  <= RC_REST[i];
      decay <= (RC_TICKS[i] == 8'h00) ? 32'hffff_ffff : 32'(RC_TICKS[i]) * TPC;
      repeat (4) @(posedge pclk);
      put(16'h0800, 1'b0);
      if (i == 0)
      begin
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[1], 1'b1)
        put(16'h1f08, 1'b1);
      end
      get_ans();
      if (RC_TICKS[i] == 8'h00)
        `CHK(ans, 32'h0003_28ff)
      else
      begin
        `CHK(ans[17:8], 10'h128)
        `CHK(ans[7:0] + 8'h01 >= RC_TICKS[i] && ans[7:0] <= RC_TICKS[i] + 8'h01, 1'b1)
      end
      `CHK(port_a_oe_n[0], 1'b1)
    end
    apb(1'b0, ADDR_PORTS, 32'h0);
    `CHK(rd, 32'h0200_f0f0)
    send(16'h1c02, 32'h0001_3c02);
    send(16'h13b0, 32'h0001_33b0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    `CHK(rd, 32'h0802_00b0)
    meas();
    `CHK(hi, 176 * TPC)
    `CHK(per, 255 * TPC)
    send(16'h1c03, 32'h0001_3c03);
    send(16'h12b0, 32'h0001_32b0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    `CHK(rd, 32'h0803_02b0)
    meas();
    `CHK(hi, 688 * TPC)
    `CHK(per, 1023 * TPC)
    // 10-bit resolution now active, meter idle, single line bus mode still set
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[2:0], 3'b101)
    // pwm is high here; disabling must pull the pin low at once
    send(16'h1c01, 32'h0001_3c01);
    `CHK(port_b_out[1], 1'b0)
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

//--- include/cpd_pkg.sv
// Functional notes
// - rc measurement uses an 8-bit counter; overflow reports no valid result
// - sample level, drive pin opposite, release, count until level returns
// - measurement counter ticks from the cpu clock derived from clock_input
// - analog read request marker 08h; answer 28h with counter value
// - every other accepted message answered: marker with bit 5 set, data byte echoed
// - control marker 1fh with 08h selects single line bus mode; answer 3fh
// - markers 03h/04h write port a out/dir, 06h/07h port b out/dir
// - pin configuration is retained across repeated analog reads
// - pwm waveform on its pin, 8-bit or 10-bit resolution
// - pwm period is twenty-five clock_input periods times two^res minus one
// - duty from two registers; upper gives top two bits in 10-bit mode
// - duty write marker bits 4..2 = 100; bits 1..0 upper, data lower
// - in 8-bit mode marker bits 1..0 ignored, only lower duty loaded
// - resolution select bit in analog_control picks 8 or 10 bit
// - enable bit in analog_control gates pwm onto pin; marker 1ch
package cpd_pkg;
  localparam logic [11:0] ADDR_MSG    = 12'h000;
  localparam logic [11:0] ADDR_ANSWER = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_CONFIG = 12'h00c;
  localparam logic [11:0] ADDR_PORTS  = 12'h010;

  localparam logic [7:0] MARK_PA_OUT  = 8'h03;
  localparam logic [7:0] MARK_PA_DIR  = 8'h04;
  localparam logic [7:0] MARK_PB_OUT  = 8'h06;
  localparam logic [7:0] MARK_PB_DIR  = 8'h07;
  localparam logic [7:0] MARK_ANALOG  = 8'h08;
  localparam logic [7:0] MARK_ACTL    = 8'h1c;
  localparam logic [7:0] MARK_CTRL    = 8'h1f;
  localparam logic [7:0] ANSWER_FLAG  = 8'h20;
  localparam logic [2:0] DUTY_SELECT  = 3'b100;

  localparam int CTRL_SINGLE_BIT = 3;
  localparam int ACT_EN_BIT      = 1;
  localparam int ACT_RES_BIT     = 0;
  localparam int SENSE_BIT       = 0;
  localparam int PWM_BIT         = 1;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  localparam int CLK_KHZ     = 25000;
  localparam int TICK_NS     = 1000;
  localparam int TICK_CYC    = (TICK_NS * CLK_KHZ) / 1000000;
  localparam logic [4:0] TICK_LAST = 5'(TICK_CYC - 1);

  localparam logic [9:0] PWM_TOP_8  = 10'h0fe;
  localparam logic [9:0] PWM_TOP_10 = 10'h3fe;

  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] CHARGE_TICKS = 8'h20;

  typedef enum logic [1:0] {
    M_IDLE   = 2'b00,
    M_SAMPLE = 2'b01,
    M_DRIVE  = 2'b10,
    M_COUNT  = 2'b11
  } cpd_meter_st_t;
endpackage : cpd_pkg

//--- logic/cpd_rc_meter.sv
`timescale 1ns/1ps
`default_nettype none
module cpd_rc_meter (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       tick,
  input  wire logic       level,
  output logic            drive_en,
  output logic            drive_val,
  output logic            done,
  output logic [7:0]      count,
  output logic            overflow
);
  import cpd_pkg::*;

  cpd_meter_st_t st_q, st_d;
  logic          orig_q, orig_d;
  logic [7:0]    cnt_q, cnt_d;
  logic          done_q, done_d;
  logic          ovf_q, ovf_d;

  always_comb
  begin
    st_d   = st_q;
    orig_d = orig_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    ovf_d  = ovf_q;
    unique case (st_q)
      M_IDLE:
        if (start)
        begin
          st_d  = M_SAMPLE;
          cnt_d = RESET_BYTE;
          ovf_d = 1'b0;
        end
      M_SAMPLE:
      begin
        orig_d = level;
        st_d   = M_DRIVE;
      end
      M_DRIVE:
        if (tick)
        begin
          if (cnt_q == CHARGE_TICKS - 8'h01)
          begin
            cnt_d = RESET_BYTE;
            st_d  = M_COUNT;
          end
          else
            cnt_d = cnt_q + 8'h01;
        end
      M_COUNT:
        if (level == orig_q)
        begin
          done_d = 1'b1;
          st_d   = M_IDLE;
        end
        else if (tick)
        begin
          if (cnt_q == COUNT_MAX)
          begin
            ovf_d  = 1'b1;
            done_d = 1'b1;
            st_d   = M_IDLE;
          end
          else
            cnt_d = cnt_q + 8'h01;
        end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q   <= M_IDLE;
      orig_q <= 1'b0;
      cnt_q  <= RESET_BYTE;
      done_q <= 1'b0;
      ovf_q  <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      orig_q <= orig_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      ovf_q  <= ovf_d;
    end
  end

  // high level charges the capacitor, low level discharges it
  assign drive_en  = (st_q == M_DRIVE);
  assign drive_val = ~orig_q;
  assign done      = done_q;
  assign count     = cnt_q;
  assign overflow  = ovf_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_drive_opposite: assert property (
    st_q == M_SAMPLE |=> drive_en && (drive_val == !$past(level)))
    else $error("drive level not opposite to sampled level");

  a_overflow_full: assert property (
    done && overflow |-> count == COUNT_MAX)
    else $error("overflow reported below full count");

  a_done_level: assert property (
    $rose(done) && !overflow |-> $past(level) == orig_q && !drive_en)
    else $error("done without original level back");
endmodule : cpd_rc_meter
`default_nettype wire

//--- logic/cpd_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpd_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  port_a_in,
  output logic [7:0]       port_a_out,
  output logic [7:0]       port_a_oe_n,
  output logic [7:0]       port_b_out,
  output logic [7:0]       port_b_oe_n,
  output logic             single_line_bus_mode
);
  import cpd_pkg::*;

  // pin input synchroniser
  logic [7:0] pa_meta_q;
  logic [7:0] pa_sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_meta_q <= RESET_BYTE;
      pa_sync_q <= RESET_BYTE;
    end
    else
    begin
      pa_meta_q <= port_a_in;
      pa_sync_q <= pa_meta_q;
    end
  end

  // apb access decode
  logic setup_ph;
  logic acc_wr;
  logic is_msg;
  logic accept;
  logic msg_analog;
  logic [7:0] msg_mark;
  logic [7:0] msg_data;

  assign setup_ph = psel & ~penable;
  assign acc_wr   = psel & penable & pwrite;
  assign is_msg   = (paddr == ADDR_MSG);
  assign msg_mark = pwdata[15:8];
  assign msg_data = pwdata[7:0];
  assign accept   = acc_wr & is_msg & ~pslverr;
  assign msg_analog = (msg_mark == MARK_ANALOG);
  assign pready   = 1'b1;

  // configuration registers
  logic [7:0] pa_out_q, pa_out_d;
  logic [7:0] pa_dir_q, pa_dir_d;
  logic [7:0] pb_out_q, pb_out_d;
  logic [7:0] pb_dir_q, pb_dir_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] act_q, act_d;
  logic [7:0] duty_lo_q, duty_lo_d;
  logic [1:0] duty_hi_q, duty_hi_d;

  always_comb
  begin
    pa_out_d  = pa_out_q;
    pa_dir_d  = pa_dir_q;
    pb_out_d  = pb_out_q;
    pb_dir_d  = pb_dir_q;
    ctrl_d    = ctrl_q;
    act_d     = act_q;
    duty_lo_d = duty_lo_q;
    duty_hi_d = duty_hi_q;
    if (accept)
    begin
      if (msg_mark == MARK_PA_OUT)
        pa_out_d = msg_data;
      if (msg_mark == MARK_PA_DIR)
        pa_dir_d = msg_data;
      if (msg_mark == MARK_PB_OUT)
        pb_out_d = msg_data;
      if (msg_mark == MARK_PB_DIR)
        pb_dir_d = msg_data;
      if (msg_mark == MARK_CTRL)
        ctrl_d = msg_data;
      if (msg_mark == MARK_ACTL)
        act_d = msg_data;
      if (msg_mark[7:5] == 3'b000 && msg_mark[4:2] == DUTY_SELECT)
      begin
        duty_lo_d = msg_data;
        if (act_q[ACT_RES_BIT])
          duty_hi_d = msg_mark[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_out_q  <= RESET_BYTE;
      pa_dir_q  <= RESET_BYTE;
      pb_out_q  <= RESET_BYTE;
      pb_dir_q  <= RESET_BYTE;
      ctrl_q    <= RESET_BYTE;
      act_q     <= RESET_BYTE;
      duty_lo_q <= RESET_BYTE;
      duty_hi_q <= 2'b00;
    end
    else
    begin
      pa_out_q  <= pa_out_d;
      pa_dir_q  <= pa_dir_d;
      pb_out_q  <= pb_out_d;
      pb_dir_q  <= pb_dir_d;
      ctrl_q    <= ctrl_d;
      act_q     <= act_d;
      duty_lo_q <= duty_lo_d;
      duty_hi_q <= duty_hi_d;
    end
  end

  assign single_line_bus_mode = ctrl_q[CTRL_SINGLE_BIT];

  // one microsecond tick: twenty-five clock_input periods at the reference rate
  logic [4:0] div_q, div_d;
  logic       tick;

  assign tick = (div_q == TICK_LAST);

  always_comb
  begin
    div_d = tick ? 5'h00 : div_q + 5'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 5'h00;
    else
      div_q <= div_d;
  end

  // r/c measurement
  logic       m_drive_en;
  logic       m_drive_val;
  logic       m_done;
  logic [7:0] m_count;
  logic       m_ovf;

  cpd_rc_meter u_meter (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (accept & msg_analog),
    .tick      (tick),
    .level     (pa_sync_q[SENSE_BIT]),
    .drive_en  (m_drive_en),
    .drive_val (m_drive_val),
    .done      (m_done),
    .count     (m_count),
    .overflow  (m_ovf)
  );

  // answer register and busy flag
  logic       busy_q, busy_d;
  logic       ans_rdy_q, ans_rdy_d;
  logic       ans_inv_q, ans_inv_d;
  logic [7:0] ans_mark_q, ans_mark_d;
  logic [7:0] ans_data_q, ans_data_d;

  always_comb
  begin
    busy_d     = busy_q;
    ans_rdy_d  = ans_rdy_q;
    ans_inv_d  = ans_inv_q;
    ans_mark_d = ans_mark_q;
    ans_data_d = ans_data_q;
    if (accept)
    begin
      ans_inv_d = 1'b0;
      if (msg_analog)
      begin
        busy_d    = 1'b1;
        ans_rdy_d = 1'b0;
      end
      else
      begin
        ans_rdy_d  = 1'b1;
        ans_mark_d = msg_mark | ANSWER_FLAG;
        ans_data_d = msg_data;
      end
    end
    if (m_done)
    begin
      busy_d     = 1'b0;
      ans_rdy_d  = 1'b1;
      ans_mark_d = MARK_ANALOG | ANSWER_FLAG;
      ans_data_d = m_count;
      ans_inv_d  = m_ovf;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q     <= 1'b0;
      ans_rdy_q  <= 1'b0;
      ans_inv_q  <= 1'b0;
      ans_mark_q <= RESET_BYTE;
      ans_data_q <= RESET_BYTE;
    end
    else
    begin
      busy_q     <= busy_d;
      ans_rdy_q  <= ans_rdy_d;
      ans_inv_q  <= ans_inv_d;
      ans_mark_q <= ans_mark_d;
      ans_data_q <= ans_data_d;
    end
  end

  // pwm counter; duty and resolution latched at period start
  logic [9:0] pcnt_q, pcnt_d;
  logic [9:0] duty_act_q, duty_act_d;
  logic       res_act_q, res_act_d;
  logic       pwm_q, pwm_d;
  logic [9:0] ptop;
  logic       pend;

  assign ptop = res_act_q ? PWM_TOP_10 : PWM_TOP_8;
  assign pend = tick && (pcnt_q == ptop);

  always_comb
  begin
    pcnt_d     = pcnt_q;
    duty_act_d = duty_act_q;
    res_act_d  = res_act_q;
    if (pend)
    begin
      pcnt_d     = 10'h000;
      res_act_d  = act_q[ACT_RES_BIT];
      duty_act_d = act_q[ACT_RES_BIT] ? {duty_hi_q, duty_lo_q}
                                      : {2'b00, duty_lo_q};
    end
    else if (tick)
      pcnt_d = pcnt_q + 10'h001;
    pwm_d = (pcnt_d < duty_act_d);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pcnt_q     <= 10'h000;
      duty_act_q <= 10'h000;
      res_act_q  <= 1'b0;
      pwm_q      <= 1'b0;
    end
    else
    begin
      pcnt_q     <= pcnt_d;
      duty_act_q <= duty_act_d;
      res_act_q  <= res_act_d;
      pwm_q      <= pwm_d;
    end
  end

  // pin drivers; oe_n low while driving
  logic [7:0] pa_o_q, pa_o_d;
  logic [7:0] pa_oe_q, pa_oe_d;
  logic [7:0] pb_o_q, pb_o_d;
  logic [7:0] pb_oe_q, pb_oe_d;

  always_comb
  begin
    pa_o_d  = pa_out_q;
    pa_oe_d = ~pa_dir_q;
    pb_o_d  = pb_out_q;
    pb_oe_d = ~pb_dir_q;
    if (busy_q)
    begin
      // meter owns the sense pin; released outside the drive phase
      pa_o_d[SENSE_BIT]  = m_drive_val;
      pa_oe_d[SENSE_BIT] = ~m_drive_en;
    end
    if (act_q[ACT_EN_BIT])
      pb_o_d[PWM_BIT] = pwm_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_o_q  <= RESET_BYTE;
      pa_oe_q <= ~RESET_BYTE;
      pb_o_q  <= RESET_BYTE;
      pb_oe_q <= ~RESET_BYTE;
    end
    else
    begin
      pa_o_q  <= pa_o_d;
      pa_oe_q <= pa_oe_d;
      pb_o_q  <= pb_o_d;
      pb_oe_q <= pb_oe_d;
    end
  end

  assign port_a_out  = pa_o_q;
  assign port_a_oe_n = pa_oe_q;
  assign port_b_out  = pb_o_q;
  assign port_b_oe_n = pb_oe_q;

  // apb read data and error, captured in the setup cycle
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;

  always_comb
  begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup_ph)
    begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      unique case (paddr)
        ADDR_MSG:
          err_d = pwrite & busy_q;
        ADDR_ANSWER:
          rdata_d = {14'h0000, ans_inv_q, ans_rdy_q, ans_mark_q, ans_data_q};
        ADDR_STATUS:
          rdata_d = {28'h0000000, pwm_q, res_act_q, busy_q, single_line_bus_mode};
        ADDR_CONFIG:
          rdata_d = {ctrl_q, act_q, 6'h00, duty_hi_q, duty_lo_q};
        ADDR_PORTS:
          rdata_d = {pb_dir_q, pb_out_q, pa_dir_q, pa_out_q};
        default:
          err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign prdata  = rdata_q;
  assign pslverr = err_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_answer_echo: assert property (
    accept && !msg_analog |=> ans_rdy_q && ans_data_q == $past(msg_data)
      && ans_mark_q == ($past(msg_mark) | ANSWER_FLAG))
    else $error("answer does not echo request");

  a_analog_answer: assert property (
    m_done |=> ans_mark_q == (MARK_ANALOG | ANSWER_FLAG) && ans_data_q == $past(m_count)
      && !busy_q)
    else $error("analog answer wrong");

  a_duty_narrow: assert property (
    accept && !act_q[ACT_RES_BIT] |=> $stable(duty_hi_q))
    else $error("upper duty loaded in 8-bit mode");

  a_duty_wide: assert property (
    accept && act_q[ACT_RES_BIT] && msg_mark == 8'h12 && msg_data == 8'hb0
      |=> duty_hi_q == 2'b10 && duty_lo_q == 8'hb0)
    else $error("10-bit duty split wrong");

  a_duty_hold: assert property (
    !pend |=> $stable(duty_act_q) && $stable(res_act_q))
    else $error("duty changed mid period");

  a_period_wrap: assert property (
    pend |=> pcnt_q == 10'h000 ##1 pcnt_q == 10'h000)
    else $error("pwm period wrap wrong");

  a_pwm_gate: assert property (
    !act_q[ACT_EN_BIT] |=> port_b_out[PWM_BIT] == $past(pb_out_q[PWM_BIT]))
    else $error("pwm leaked while disabled");

  a_config_kept: assert property (
    accept && msg_analog |=> ($stable(pa_dir_q) && $stable(pa_out_q)) [*2])
    else $error("pin config lost on analog read");

  c_analog_read: cover property (m_done && !m_ovf);
  c_overflow: cover property (m_done && m_ovf);
  c_pwm_wide: cover property (pend && act_q[ACT_RES_BIT] && act_q[ACT_EN_BIT]);
endmodule : cpd_top
`default_nettype wire
